/* adcrs_addr_sel.sv */
// slave address selection from package option and strap pins
`timescale 1ns/1ps
module adcrs_addr_sel
	import adcrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic eightPinPackage,
	input wire logic clockSourceSelectPin,
	input wire logic addressStrapLow,
	input wire logic addressStrapHigh,
	output logic [7:0] slaveAddress
);
	logic [1:0] strapPair;
	logic [7:0] strapAddress;
	logic [7:0] next_slaveAddress;

	// RULE_15 strap address map
	assign strapPair = {addressStrapHigh, addressStrapLow};
	assign strapAddress = (strapPair == 2'h0) ? ADDR_STRAP_00 :
		(strapPair == 2'h1) ? ADDR_STRAP_01 :
		(strapPair == 2'h2) ? ADDR_STRAP_10 : ADDR_STRAP_11;
	// RULE_16 eight pin fixed
	// RULE_14 crystal mode default
	assign next_slaveAddress = eightPinPackage ? ADDR_EIGHT_PIN :
		(clockSourceSelectPin ? strapAddress : ADDR_STRAP_00);

	// registered so a strap is sampled by the clock, never by the reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slaveAddress <= ADDR_STRAP_00;
		end else begin
			slaveAddress <= next_slaveAddress;
		end
	end
endmodule // adcrs_addr_sel

/* adcrs_i2c_master.sv */
// behavioural bus master that clocks frames into the slave
`timescale 1ns/1ps
module adcrs_i2c_master (
	input wire logic core_clk,
	input wire logic sdaIn,
	output logic sclPull,
	output logic sdaPull
);
	// both lines released at power-up
	initial begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic bitIo(input logic b, output logic r);
		sdaPull = !b;
		tick(4);
		sclPull = 1'b0;
		tick(4);
		r = sdaIn;
		tick(4);
		sclPull = 1'b1;
		tick(1);
	endtask
	// long low wait lets the slave drop its pull first
	task automatic start();
		sdaPull = 1'b0;
		tick(4);
		sclPull = 1'b0;
		tick(4);
		sdaPull = 1'b1;
		tick(4);
		sclPull = 1'b1;
		tick(1);
	endtask
	task automatic stop();
		sdaPull = 1'b1;
		tick(4);
		sclPull = 1'b0;
		tick(4);
		sdaPull = 1'b0;
		tick(4);
	endtask
	task automatic xfer(input logic [7:0] v, input logic ackOut,
		output logic [7:0] got, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitIo(v[i], got[i]);
		bitIo(ackOut, ack);
	endtask
	task automatic wr(input logic [7:0] dev, ra, d, output logic [2:0] a);
		logic [7:0] g;
		start();
		xfer(dev, 1'b1, g, a[2]);
		xfer(ra, 1'b1, g, a[1]);
		xfer(d, 1'b1, g, a[0]);
		stop();
	endtask
	task automatic rd(input logic [7:0] dev, ra, output logic [7:0] d,
		output logic [2:0] a);
		logic [7:0] g;
		logic n;
		start();
		xfer(dev, 1'b1, g, a[2]);
		xfer(ra, 1'b1, g, a[1]);
		start();
		xfer(dev | 8'h01, 1'b1, g, a[0]);
		xfer(8'hFF, 1'b1, d, n);
		stop();
	endtask
endmodule // adcrs_i2c_master

/* adcrs_monitor.sv */
// assertion checker for the serial slave port
`timescale 1ns/1ps
module adcrs_monitor
	import adcrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input adcrs_bus_in_t busIn,
	input adcrs_bus_out_t busOut,
	input wire logic converterPowerOff,
	input wire logic tempSensorSelect,
	input wire logic [15:0] dacValue
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// clock seen high on two edges running
	sequence sclHeld;
		busIn.scl [*2];
	endsequence
	a_scl_untouched: assert property (
		!busOut.sclOe && !busOut.sclOut) else $error("slave drove clock");
	a_sda_low_only: assert property (
		!busOut.sdaOut) else $error("data driven high");
	a_sda_steady_high: assert property (
		sclHeld |-> $stable(busOut.sdaOe)) else $error("data moved in high");
	a_pull_while_low: assert property (
		$rose(busOut.sdaOe) |-> !busIn.scl && !$past(busIn.scl))
		else $error("pull not in low phase");
	a_pull_held: assert property (
		$rose(busOut.sdaOe) |=> busOut.sdaOe [*2]) else $error("pull too short");
	a_release_low: assert property (
		$fell(busOut.sdaOe) |-> !busIn.scl) else $error("release in high");
	a_write_at_bit: assert property (
		$changed({converterPowerOff, tempSensorSelect, dacValue}) |-> !busIn.scl)
		else $error("register moved while clock high");
	a_reset_values: assert property (
		$rose(reset_n) |-> converterPowerOff && dacValue == 16'h0000)
		else $error("bad reset values");
endmodule // adcrs_monitor
bind adcrs_result_regs adcrs_monitor adcrs_monitor_inst (.core_clk(core_clk),
	.reset_n(reset_n), .busIn(busIn), .busOut(busOut),
	.converterPowerOff(converterPowerOff),
	.tempSensorSelect(tempSensorSelect), .dacValue(dacValue));

/* adcrs_pkg.sv */
// shared constants and types for the result register and serial slave block
package adcrs_pkg;
	// register map (byte addresses on the serial port)
	localparam logic [7:0] REG_RESULT_LOW = 8'h04;
	localparam logic [7:0] REG_RESULT_MID = 8'h05;
	localparam logic [7:0] REG_RESULT_HIGH = 8'h06;
	localparam logic [7:0] REG_CONV_CTRL = 8'h07;
	localparam logic [7:0] REG_CONV_STAT = 8'h08;
	localparam logic [7:0] REG_DAC_LOW = 8'h0B;
	localparam logic [7:0] REG_DAC_HIGH = 8'h0C;
	// field positions
	localparam int POWER_OFF_BIT = 0;
	localparam int TEMP_SEL_BIT = 1;
	localparam int EOC_BIT = 1;
	// reset values
	localparam logic [7:0] CONV_CTRL_RESET = 8'h01;
	localparam logic [7:0] DAC_RESET = 8'h00;
	// saturation limits of the 24-bit two's complement result
	localparam logic signed [23:0] RESULT_MAX = 24'sh7FFFFF;
	localparam logic signed [23:0] RESULT_MIN = -24'sh800000;
	// slave addresses (8-bit form, write bit clear)
	localparam logic [7:0] ADDR_STRAP_00 = 8'hA0;
	localparam logic [7:0] ADDR_STRAP_01 = 8'hB0;
	localparam logic [7:0] ADDR_STRAP_10 = 8'hC0;
	localparam logic [7:0] ADDR_STRAP_11 = 8'hD0;
	localparam logic [7:0] ADDR_EIGHT_PIN = 8'hD0;
	localparam int BITS_PER_BYTE = 8;
	// serial bus lines as seen and driven by the slave
	typedef struct packed {
		logic scl;
		logic sda;
	} adcrs_bus_in_t;
	typedef struct packed {
		logic sclOut;
		logic sclOe;
		logic sdaOut;
		logic sdaOe;
	} adcrs_bus_out_t;
	// raw sample from the modulator/filter, wider than the result for headroom
	typedef struct packed {
		logic valid;
		logic signed [31:0] value;
	} adcrs_sample_t;
endpackage

/* adcrs_result_regs.sv */
// result registers, converter control and serial slave port
`timescale 1ns/1ps
// How it works
// RULE_01 - result is 24-bit two's complement, top bit is the sign
// RULE_02 - results clamp to 8388607 and -8388608, never wrap
// RULE_03 - result bits 7..0 read-only at address 04H
// RULE_04 - result bits 15..8 read-only at address 05H
// RULE_05 - result bits 23..16 with sign read-only at address 06H
// RULE_06 - power-off bit high switches off all converter circuitry
// RULE_07 - dac low write goes to shadow, moved on high-byte write
// RULE_08 - host writes dac low byte first, then high byte
// RULE_09 - slave only, never starts transfers nor drives clock
// RULE_10 - only the external master drives the clock line
// RULE_11 - both lines open-drain: pull low or release
// RULE_12 - no chip select, selected by address match only
// RULE_13 - supports slave transmit and slave receive
// RULE_14 - clock select low gives address 0xA0
// RULE_15 - clock select high: straps pick A0, B0, C0 or D0
// RULE_16 - eight-pin package always answers at 0xD0
// RULE_17 - temperature sensor channel converts through normal path
// RULE_18 - bytes are 8 bits msb first plus acknowledge bit
// RULE_19 - on missing master acknowledge, release data line
// RULE_20 - end of conversion flag sets on completion, software clears
// RULE_21 - write: addr, reg, data; read: reg, repeated start, data
// RULE_22 - unmatched address not acknowledged, ignored until next start
module adcrs_result_regs
	import adcrs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input adcrs_bus_in_t busIn,
	output adcrs_bus_out_t busOut,
	input wire logic eightPinPackage,
	input wire logic clockSourceSelectPin,
	input wire logic addressStrapLow,
	input wire logic addressStrapHigh,
	input adcrs_sample_t signalSample,
	input adcrs_sample_t tempSample,
	output logic converterPowerOff,
	output logic tempSensorSelect,
	output logic [15:0] dacValue
);
	typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE} adcrs_state_t;

	adcrs_state_t state;
	adcrs_state_t next_state;
	logic [7:0] slaveAddress;
	logic sclPrev;
	logic sdaPrev;
	logic [3:0] bitCount;
	logic [7:0] shiftIn;
	logic [7:0] shiftOut;
	logic [7:0] regPointer;
	logic sdaLow;
	logic [23:0] result;
	logic [7:0] convCtrl;
	logic eocFlag;
	logic [7:0] dacShadow;
	logic [7:0] dacLow;
	logic [7:0] dacHigh;

	adcrs_addr_sel addrSel (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.eightPinPackage(eightPinPackage),
		.clockSourceSelectPin(clockSourceSelectPin),
		.addressStrapLow(addressStrapLow),
		.addressStrapHigh(addressStrapHigh),
		.slaveAddress(slaveAddress)
	);

	// bus line events, lines are already synchronous to core_clk
	wire sclRise = busIn.scl & ~sclPrev;
	wire sclFall = ~busIn.scl & sclPrev;
	wire startSeen = busIn.scl & sclPrev & sdaPrev & ~busIn.sda;
	wire stopSeen = busIn.scl & sclPrev & ~sdaPrev & busIn.sda;
	wire byteDone = (bitCount == 4'(BITS_PER_BYTE));
	// the whole byte sits in the shifter once its eighth rise is taken
	wire [7:0] rxByte = shiftIn;

	// RULE_12 address match select
	wire addrMatch = (rxByte[7:1] == slaveAddress[7:1]);
	wire readReq = rxByte[0];

	// samples the converter; temperature channel uses the same path
	// RULE_17 temp sensor path
	wire adcrs_sample_t chosen = convCtrl[TEMP_SEL_BIT] ? tempSample :
		signalSample;
	// RULE_06 powered off gating
	wire sampleTaken = chosen.valid & ~convCtrl[POWER_OFF_BIT];
	// RULE_02 saturate result
	wire signed [23:0] clamped =
		(chosen.value > 32'(signed'(RESULT_MAX))) ? RESULT_MAX :
		(chosen.value < 32'(signed'(RESULT_MIN))) ? RESULT_MIN :
		chosen.value[23:0];

	// register read decode, unmapped addresses read zero
	// RULE_03 low result byte
	// RULE_04 mid result byte
	// RULE_05 high result byte
	wire [7:0] readData =
		(regPointer == REG_RESULT_LOW) ? result[7:0] :
		(regPointer == REG_RESULT_MID) ? result[15:8] :
		(regPointer == REG_RESULT_HIGH) ? result[23:16] :
		(regPointer == REG_CONV_CTRL) ? convCtrl :
		(regPointer == REG_CONV_STAT) ? (8'(eocFlag) << EOC_BIT) :
		(regPointer == REG_DAC_LOW) ? dacLow :
		(regPointer == REG_DAC_HIGH) ? dacHigh : 8'h00;

	// write strobe as the data byte's last clock falls
	wire writeStrobe = (state == ST_WDATA) & sclFall & byteDone;
	wire eocClear = writeStrobe & (regPointer == REG_CONV_STAT) &
		~rxByte[EOC_BIT];

	// next state of the serial engine; bytes end on the eighth fall so
	// the pull-down only ever moves while the clock is low
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = ST_IDLE;
			ST_ADDR: begin
				// RULE_22 ignore other address
				if (sclFall && byteDone) begin
					next_state = addrMatch ? ST_ADDR_ACK : ST_IGNORE;
				end
			end
			ST_ADDR_ACK: begin
				if (sclFall) begin
					next_state = shiftOut[0] ? ST_RDATA : ST_REG;
				end
			end
			ST_REG: if (sclFall && byteDone) next_state = ST_REG_ACK;
			ST_REG_ACK: if (sclFall) next_state = ST_WDATA;
			ST_WDATA: if (sclFall && byteDone) next_state = ST_WDATA_ACK;
			ST_WDATA_ACK: if (sclFall) next_state = ST_WDATA;
			ST_RDATA: if (sclFall && byteDone) next_state = ST_RDATA_ACK;
			ST_RDATA_ACK: begin
				// RULE_19 release on nack
				if (sclRise && busIn.sda) begin
					next_state = ST_IGNORE;
				end else if (sclFall) begin
					next_state = ST_RDATA;
				end
			end
			ST_IGNORE: next_state = ST_IGNORE;
			default: next_state = ST_IDLE;
		endcase
		// RULE_21 repeated start frames
		if (startSeen) begin
			next_state = ST_ADDR;
		end else if (stopSeen) begin
			next_state = ST_IDLE;
		end
	end

	// line history for edge and condition detection
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			state <= ST_IDLE;
		end else begin
			sclPrev <= busIn.scl;
			sdaPrev <= busIn.sda;
			state <= next_state;
		end
	end

	// RULE_18 msb first bit counting
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bitCount <= 4'h0;
			shiftIn <= 8'h00;
		end else if (startSeen || next_state != state) begin
			bitCount <= 4'h0;
		end else if (sclRise) begin
			bitCount <= bitCount + 4'h1;
			shiftIn <= {shiftIn[6:0], busIn.sda};
		end
	end

	// pointer and outgoing byte; pointer auto-increments with each data byte
	// RULE_13 transmit and receive
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			regPointer <= 8'h00;
			shiftOut <= 8'h00;
		end else if (state == ST_ADDR && sclFall && byteDone) begin
			shiftOut <= {7'h00, readReq};
		end else if (state == ST_REG && sclFall && byteDone) begin
			regPointer <= rxByte;
		end else if (writeStrobe) begin
			regPointer <= regPointer + 8'h01;
		end else if (next_state == ST_RDATA && state != ST_RDATA) begin
			shiftOut <= readData;
			regPointer <= regPointer + 8'h01;
		end else if (state == ST_RDATA && sclFall) begin
			shiftOut <= {shiftOut[6:0], 1'b0};
		end
	end

	// data line pull-down: acknowledge slots and transmitted zeros
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sdaLow <= 1'b0;
		end else begin
			case (next_state)
				ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: sdaLow <= 1'b1;
				ST_RDATA: sdaLow <= (state == ST_RDATA) ?
					((sclFall) ? ~shiftOut[6] : sdaLow) : ~readData[7];
				default: sdaLow <= 1'b0;
			endcase
		end
	end

	// RULE_11 open drain lines
	// RULE_09 clock never driven
	assign busOut.sdaOut = 1'b0;
	assign busOut.sdaOe = sdaLow;
	assign busOut.sclOut = 1'b0;
	assign busOut.sclOe = 1'b0;

	// RULE_01 two's complement result
	// no reset: contents are undefined after power-on
	always_ff @(posedge core_clk) begin
		if (sampleTaken) begin
			result <= clamped;
		end
	end

	// control register and end-of-conversion flag
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			convCtrl <= CONV_CTRL_RESET;
			eocFlag <= 1'b0;
		end else begin
			if (writeStrobe && regPointer == REG_CONV_CTRL) begin
				convCtrl <= rxByte;
			end
			// RULE_20 set wins clear
			if (sampleTaken) begin
				eocFlag <= 1'b1;
			end else if (eocClear) begin
				eocFlag <= 1'b0;
			end
		end
	end

	// RULE_07 dac shadow transfer
	// RULE_08 low then high
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dacShadow <= DAC_RESET;
			dacLow <= DAC_RESET;
			dacHigh <= DAC_RESET;
		end else if (writeStrobe && regPointer == REG_DAC_LOW) begin
			dacShadow <= rxByte;
		end else if (writeStrobe && regPointer == REG_DAC_HIGH) begin
			dacHigh <= rxByte;
			dacLow <= dacShadow;
		end
	end

	// RULE_06 power off output
	assign converterPowerOff = convCtrl[POWER_OFF_BIT];
	assign tempSensorSelect = convCtrl[TEMP_SEL_BIT];
	assign dacValue = {dacHigh, dacLow};
endmodule // adcrs_result_regs

/* adcrs_result_regs_test.sv */
// self-checking bench for the result register serial slave
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adcrs_result_regs_test
	import adcrs_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic sclPull, sdaPull, eightPinPackage, clockSourceSelectPin;
	logic addressStrapLow, addressStrapHigh, converterPowerOff;
	logic tempSensorSelect;
	logic [15:0] dacValue;
	adcrs_bus_in_t busIn;
	adcrs_bus_out_t busOut;
	adcrs_sample_t signalSample = '0;
	adcrs_sample_t tempSample = '0;
	int errors = 0;
	int checked = 0;
	int seed = 18;
	logic [7:0] dev, rb;
	logic [2:0] ack;
	logic [31:0] v;
	logic [31:0] corner [4] = '{32'h007FFFFF, 32'h00800000, 32'hFF800000,
		32'hFF7FFFFF};
	// open-drain lines with pull-ups: released reads high
	assign busIn.scl = !(sclPull | busOut.sclOe);
	assign busIn.sda = !(sdaPull | busOut.sdaOe);
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	adcrs_i2c_master adcrs_i2c_master_inst (.core_clk(core_clk),
		.sdaIn(busIn.sda), .sclPull(sclPull), .sdaPull(sdaPull));
	adcrs_result_regs adcrs_result_regs_inst (.core_clk(core_clk),
		.reset_n(reset_n), .busIn(busIn), .busOut(busOut),
		.eightPinPackage(eightPinPackage),
		.clockSourceSelectPin(clockSourceSelectPin),
		.addressStrapLow(addressStrapLow),
		.addressStrapHigh(addressStrapHigh), .signalSample(signalSample),
		.tempSample(tempSample), .converterPowerOff(converterPowerOff),
		.tempSensorSelect(tempSensorSelect), .dacValue(dacValue));
	// k = {package, clock select, strap high, strap low}
	function automatic logic [7:0] expAddr(input logic [3:0] k);
		if (k[3])
			return 8'hD0;
		if (!k[2])
			return 8'hA0;
		return 8'hA0 + {k[1:0], 4'h0};
	endfunction
	// clamp a wide sample to the signed 24-bit range
	function automatic logic [23:0] sat(input logic signed [31:0] x);
		if (x > 32'sh007FFFFF)
			return 24'h7FFFFF;
		if (x < -32'sh00800000)
			return 24'h800000;
		return x[23:0];
	endfunction
	// pins are sampled on every clock; each option still gets its own reset
	task automatic doReset(input logic [3:0] k);
		reset_n = 1'b0;
		{eightPinPackage, clockSourceSelectPin} = k[3:2];
		{addressStrapHigh, addressStrapLow} = k[1:0];
		repeat (4) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic w(input logic [7:0] ra, d);
		adcrs_i2c_master_inst.wr(dev, ra, d, ack);
		`CHK(ack, 3'b000)
	endtask
	task automatic r(input logic [7:0] ra);
		adcrs_i2c_master_inst.rd(dev, ra, rb, ack);
	endtask
	task automatic pulse(input logic [31:0] s, t);
		signalSample = {1'b1, s};
		tempSample = {1'b1, t};
		@(negedge core_clk);
		signalSample.valid = 1'b0;
		tempSample.valid = 1'b0;
	endtask
	task automatic chkResult(input logic [23:0] e);
		for (int i = 0; i < 3; i++) begin
			r(REG_RESULT_LOW + 8'(i));
			`CHK(rb, e[8*i +: 8])
		end
	endtask
	task automatic stop_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		for (int k = 0; k < 9; k++) begin
			doReset(4'(k));
			`CHK({converterPowerOff, dacValue}, 17'h10000)
			dev = expAddr(4'(k)) ^ 8'h10;
			r(REG_CONV_CTRL);
			`CHK({ack, rb}, 11'h7FF)
			dev = expAddr(4'(k));
			w(REG_CONV_CTRL, 8'h00);
			`CHK(converterPowerOff, 1'b0)
		end
		$display("address test done");
		// limits first, then random values of shrinking size
		for (int i = 0; i < 8; i++) begin
			v = (i < 4) ? corner[i] : $random(seed) >>> (4 * (i - 4));
			pulse(v, ~v);
			chkResult(sat(v));
		end
		r(REG_CONV_STAT);
		`CHK(rb[EOC_BIT], 1'b1)
		w(REG_CONV_STAT, 8'h00);
		r(REG_CONV_STAT);
		`CHK(rb[EOC_BIT], 1'b0)
		r(8'h3F);
		`CHK(rb, 8'h00)
		w(REG_CONV_CTRL, 8'h02);
		`CHK(tempSensorSelect, 1'b1)
		pulse(32'h00012345, 32'hFFFEDCBA);
		chkResult(24'hFEDCBA);
		w(REG_CONV_CTRL, 8'h01);
		pulse(32'h00000000, 32'h00000000);
		adcrs_i2c_master_inst.wr(dev, REG_RESULT_HIGH, 8'h5A, ack);
		chkResult(24'hFEDCBA);
		$display("result test done");
		v = $random(seed);
		w(REG_DAC_LOW, v[7:0]);
		`CHK(dacValue, 16'h0000)
		w(REG_DAC_HIGH, v[15:8]);
		`CHK(dacValue, v[15:0])
		r(REG_DAC_LOW);
		`CHK(rb, v[7:0])
		$display("dac test done");
		stop_test();
	end
	// hang guard, nearly four times the expected run
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		stop_test();
	end
endmodule // adcrs_result_regs_test
